// [shared/fpscn_pkg.sv]
// Functional notes
// - Sign bit clear means positive, set means negative, for every class.
// - Significand is one integer bit plus fraction; integer bit is implied.
// - Stored exponent equals true exponent plus bias 127.
// - Normalizing shifts out leading zeros, exponent drops one per zero.
// - Each operand falls into exactly one of six classes.
// - Plus zero and minus zero compare equal; each zero keeps its sign.
// - Non-zero value with biased exponent 1 through 254 is normal.
// - Biased exponent zero with non-zero fraction is denormal, integer bit 0.
// - Tiny results shift right, exponent rising, until exponent reaches -126.
// - All bits shifted out gives zero with the original sign.
// - Normalize whenever range allows; denormal only when unavoidable.
// - Creating a denormal result raises the underflow flag.
// - Any denormal source operand raises the denormal-operand flag.
// - Maximum exponent 255 with zero fraction is infinity.
// - Maximum exponent with non-zero fraction is NaN, sign ignored.
// - Top fraction bit set means quiet NaN, clear means signaling NaN.
package fpscn_pkg;

  // ----------------------------------------------------------------
  // Word layout
  // ----------------------------------------------------------------
  localparam int WORD_W = 32;
  localparam int EXP_W = 8;
  localparam int FRAC_W = 23;
  localparam int SIG_W = 24;
  localparam int TEXP_W = 10;
  localparam int XEXP_W = 11;
  localparam int LZ_W = 5;
  localparam int SIGN_POS = 31;
  localparam int EXP_MSB = 30;
  localparam int EXP_LSB = 23;
  localparam int FRAC_MSB = 22;
  localparam int INT_POS = 23;

  // ----------------------------------------------------------------
  // Exponent, fraction, significand and shift-count constants
  // ----------------------------------------------------------------
  localparam logic [EXP_W-1:0] EXP_ZERO = 8'h00;
  localparam logic [EXP_W-1:0] EXP_MAX = 8'hff;
  localparam logic signed [XEXP_W-1:0] BIAS = 11'sh07f;
  localparam logic signed [XEXP_W-1:0] EMIN = -11'sh07e;
  localparam logic signed [XEXP_W-1:0] EMAX = 11'sh07f;
  localparam logic signed [XEXP_W-1:0] SIG_W_X = 11'sh018;
  localparam logic [FRAC_W-1:0] FRAC_ZERO = 23'h000000;
  localparam logic [FRAC_W-1:0] FRAC_INDEF = 23'h400000;
  localparam logic [SIG_W-1:0] SIG_ZERO = 24'h000000;
  localparam logic [LZ_W-1:0] LZ_ONE = 5'h01;

  // ----------------------------------------------------------------
  // Operand classes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    FPSCN_ZERO = 3'b000,
    FPSCN_DENORMAL = 3'b001,
    FPSCN_NORMAL = 3'b010,
    FPSCN_INFINITY = 3'b011,
    FPSCN_NAN = 3'b100,
    FPSCN_INDEFINITE = 3'b101
  } fpscn_class_t;

endpackage : fpscn_pkg

// [design/fpscn_classify.sv]
`timescale 1ns/1ps
module fpscn_classify (
  input wire logic sign,
  input wire logic [fpscn_pkg::EXP_W-1:0] exp_field,
  input wire logic [fpscn_pkg::FRAC_W-1:0] frac,
  output fpscn_pkg::fpscn_class_t cls,
  output logic quiet_not_a_number,
  output logic signaling_not_a_number
);

  logic exp_is_zero;
  logic exp_is_max;
  logic frac_is_zero;
  logic nan_any;

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  assign exp_is_zero = (exp_field == fpscn_pkg::EXP_ZERO);
  assign exp_is_max = (exp_field == fpscn_pkg::EXP_MAX);
  assign frac_is_zero = (frac == fpscn_pkg::FRAC_ZERO);
  assign nan_any = exp_is_max && !frac_is_zero;

  // Quiet or signaling by top fraction bit
  assign quiet_not_a_number = nan_any && frac[fpscn_pkg::FRAC_MSB];
  assign signaling_not_a_number = nan_any && !frac[fpscn_pkg::FRAC_MSB];

  // One class per word, indefinite checked before plain NaN
  always_comb
  begin
    if (exp_is_zero && frac_is_zero)
      cls = fpscn_pkg::FPSCN_ZERO;
    else if (exp_is_zero)
      cls = fpscn_pkg::FPSCN_DENORMAL;
    else if (exp_is_max && frac_is_zero)
      cls = fpscn_pkg::FPSCN_INFINITY;
    else if (exp_is_max && sign && (frac == fpscn_pkg::FRAC_INDEF))
      cls = fpscn_pkg::FPSCN_INDEFINITE;
    else if (exp_is_max)
      cls = fpscn_pkg::FPSCN_NAN;
    else
      cls = fpscn_pkg::FPSCN_NORMAL;
  end

endmodule : fpscn_classify

// [design/fpscn_top.sv]
`timescale 1ns/1ps
module fpscn_top (
  input wire logic clk,
  input wire logic srst,
  input wire logic in_valid,
  input wire logic op_a_sign,
  input wire logic [fpscn_pkg::EXP_W-1:0] op_a_exp,
  input wire logic [fpscn_pkg::FRAC_W-1:0] op_a_frac,
  input wire logic op_b_sign,
  input wire logic [fpscn_pkg::EXP_W-1:0] op_b_exp,
  input wire logic [fpscn_pkg::FRAC_W-1:0] op_b_frac,
  input wire logic res_sign,
  input wire logic signed [fpscn_pkg::TEXP_W-1:0] res_exp,
  input wire logic [fpscn_pkg::SIG_W-1:0] res_sig,
  output logic out_valid,
  output fpscn_pkg::fpscn_class_t op_a_class,
  output logic op_a_negative,
  output logic op_a_quiet_not_a_number,
  output logic op_a_signaling_not_a_number,
  output fpscn_pkg::fpscn_class_t op_b_class,
  output logic op_b_negative,
  output logic op_b_quiet_not_a_number,
  output logic op_b_signaling_not_a_number,
  output logic ops_equal,
  output logic [fpscn_pkg::WORD_W-1:0] result_word,
  output logic underflow,
  output logic overflow,
  output logic denormal_operand
);

  localparam int NUM_OPS = 2;

  // ----------------------------------------------------------------
  // Operand fan-in
  // ----------------------------------------------------------------
  logic op_sign [NUM_OPS];
  logic [fpscn_pkg::EXP_W-1:0] op_exp [NUM_OPS];
  logic [fpscn_pkg::FRAC_W-1:0] op_frac [NUM_OPS];
  fpscn_pkg::fpscn_class_t cls_nxt [NUM_OPS];
  logic quiet_nxt [NUM_OPS];
  logic signaling_nxt [NUM_OPS];
  fpscn_pkg::fpscn_class_t cls_r [NUM_OPS];
  logic neg_r [NUM_OPS];
  logic quiet_r [NUM_OPS];
  logic signaling_r [NUM_OPS];

  // Operand A and B into indexed form
  assign op_sign[0] = op_a_sign;
  assign op_exp[0] = op_a_exp;
  assign op_frac[0] = op_a_frac;
  assign op_sign[1] = op_b_sign;
  assign op_exp[1] = op_b_exp;
  assign op_frac[1] = op_b_frac;

  // ----------------------------------------------------------------
  // Per-operand classification
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NUM_OPS; gi++)
    begin : g_op
      fpscn_classify u_classify (
        .sign(op_sign[gi]),
        .exp_field(op_exp[gi]),
        .frac(op_frac[gi]),
        .cls(cls_nxt[gi]),
        .quiet_not_a_number(quiet_nxt[gi]),
        .signaling_not_a_number(signaling_nxt[gi])
      );

      // Class and NaN kind held until the next transfer
      always_ff @(posedge clk)
      begin
        if (srst)
        begin
          cls_r[gi] <= fpscn_pkg::FPSCN_ZERO;
          quiet_r[gi] <= 1'b0;
          signaling_r[gi] <= 1'b0;
        end
        else if (in_valid)
        begin
          cls_r[gi] <= cls_nxt[gi];
          quiet_r[gi] <= quiet_nxt[gi];
          signaling_r[gi] <= signaling_nxt[gi];
        end
      end

      // Sign reported for every class, zeros included
      always_ff @(posedge clk)
      begin
        if (srst)
          neg_r[gi] <= 1'b0;
        else if (in_valid)
          neg_r[gi] <= op_sign[gi];
      end
    end
  endgenerate

  // Operand outputs straight from the flops
  assign op_a_class = cls_r[0];
  assign op_a_negative = neg_r[0];
  assign op_a_quiet_not_a_number = quiet_r[0];
  assign op_a_signaling_not_a_number = signaling_r[0];
  assign op_b_class = cls_r[1];
  assign op_b_negative = neg_r[1];
  assign op_b_quiet_not_a_number = quiet_r[1];
  assign op_b_signaling_not_a_number = signaling_r[1];

  // ----------------------------------------------------------------
  // Operand compare and denormal detection
  // ----------------------------------------------------------------
  logic a_is_nan;
  logic b_is_nan;
  logic both_zero;
  logic same_bits;
  logic equal_nxt;
  logic denorm_op_nxt;

  assign a_is_nan = (cls_nxt[0] == fpscn_pkg::FPSCN_NAN) ||
                    (cls_nxt[0] == fpscn_pkg::FPSCN_INDEFINITE);
  assign b_is_nan = (cls_nxt[1] == fpscn_pkg::FPSCN_NAN) ||
                    (cls_nxt[1] == fpscn_pkg::FPSCN_INDEFINITE);
  assign both_zero = (cls_nxt[0] == fpscn_pkg::FPSCN_ZERO) &&
                     (cls_nxt[1] == fpscn_pkg::FPSCN_ZERO);
  assign same_bits = (op_sign[0] == op_sign[1]) && (op_exp[0] == op_exp[1]) &&
                     (op_frac[0] == op_frac[1]);

  // Zeros equal whatever their signs; a NaN equals nothing
  assign equal_nxt = !a_is_nan && !b_is_nan && (both_zero || same_bits);

  // Either source denormal
  assign denorm_op_nxt = (cls_nxt[0] == fpscn_pkg::FPSCN_DENORMAL) ||
                         (cls_nxt[1] == fpscn_pkg::FPSCN_DENORMAL);

  // ----------------------------------------------------------------
  // Result normalize and denormalize
  // ----------------------------------------------------------------
  function automatic logic [fpscn_pkg::LZ_W-1:0] fpscn_lzc(
    input logic [fpscn_pkg::SIG_W-1:0] v
  );
    logic [fpscn_pkg::LZ_W-1:0] n;
    logic found;
    n = '0;
    found = 1'b0;
    for (int i = fpscn_pkg::SIG_W - 1; i >= 0; i--)
    begin
      if (!found)
      begin
        if (v[i])
          found = 1'b1;
        else
          n = n + fpscn_pkg::LZ_ONE;
      end
    end
    return n;
  endfunction : fpscn_lzc

  logic signed [fpscn_pkg::XEXP_W-1:0] exp_x;
  logic signed [fpscn_pkg::XEXP_W-1:0] room;
  logic signed [fpscn_pkg::XEXP_W-1:0] rsh;
  logic signed [fpscn_pkg::XEXP_W-1:0] exp_n;
  logic signed [fpscn_pkg::XEXP_W-1:0] biased;
  logic [fpscn_pkg::LZ_W-1:0] lz;
  logic [fpscn_pkg::LZ_W-1:0] sh;
  logic [fpscn_pkg::SIG_W-1:0] sig_n;
  logic [fpscn_pkg::WORD_W-1:0] word_nxt;
  logic uf_nxt;
  logic ovf_nxt;

  // Shift amounts from the true exponent
  always_comb
  begin
    exp_x = {res_exp[fpscn_pkg::TEXP_W-1], res_exp};
    lz = fpscn_lzc(res_sig);
    room = exp_x - fpscn_pkg::EMIN;
    rsh = fpscn_pkg::EMIN - exp_x;
    if (room < $signed({6'h00, lz}))
      sh = room[fpscn_pkg::LZ_W-1:0];
    else
      sh = lz;
  end

  // Significand and exponent after the shift
  always_comb
  begin
    sig_n = fpscn_pkg::SIG_ZERO;
    exp_n = fpscn_pkg::EMIN;
    if (res_sig == fpscn_pkg::SIG_ZERO)
    begin
      sig_n = fpscn_pkg::SIG_ZERO;
      exp_n = fpscn_pkg::EMIN;
    end
    else if (exp_x < fpscn_pkg::EMIN)
    begin
      if (rsh >= fpscn_pkg::SIG_W_X)
        sig_n = fpscn_pkg::SIG_ZERO;
      else
        sig_n = res_sig >> rsh[fpscn_pkg::LZ_W-1:0];
      exp_n = fpscn_pkg::EMIN;
    end
    else
    begin
      sig_n = res_sig << sh;
      exp_n = exp_x - $signed({6'h00, sh});
    end
  end

  // Pack sign, biased exponent and fraction
  always_comb
  begin
    biased = exp_n + fpscn_pkg::BIAS;
    word_nxt = '0;
    ovf_nxt = 1'b0;
    uf_nxt = 1'b0;
    word_nxt[fpscn_pkg::SIGN_POS] = res_sign;
    if (sig_n[fpscn_pkg::INT_POS] && (exp_n > fpscn_pkg::EMAX))
    begin
      word_nxt[fpscn_pkg::EXP_MSB:fpscn_pkg::EXP_LSB] = fpscn_pkg::EXP_MAX;
      ovf_nxt = 1'b1;
    end
    else if (sig_n[fpscn_pkg::INT_POS])
    begin
      word_nxt[fpscn_pkg::EXP_MSB:fpscn_pkg::EXP_LSB] = biased[fpscn_pkg::EXP_W-1:0];
      word_nxt[fpscn_pkg::FRAC_MSB:0] = sig_n[fpscn_pkg::FRAC_MSB:0];
    end
    else
    begin
      word_nxt[fpscn_pkg::EXP_MSB:fpscn_pkg::EXP_LSB] = fpscn_pkg::EXP_ZERO;
      word_nxt[fpscn_pkg::FRAC_MSB:0] = sig_n[fpscn_pkg::FRAC_MSB:0];
      uf_nxt = (res_sig != fpscn_pkg::SIG_ZERO);
    end
  end

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------

  // One-cycle transfer marker
  always_ff @(posedge clk)
  begin
    if (srst)
      out_valid <= 1'b0;
    else
      out_valid <= in_valid;
  end

  // Result word held until the next transfer
  always_ff @(posedge clk)
  begin
    if (srst)
      result_word <= '0;
    else if (in_valid)
      result_word <= word_nxt;
  end

  // Compare result held with the classes
  always_ff @(posedge clk)
  begin
    if (srst)
      ops_equal <= 1'b0;
    else if (in_valid)
      ops_equal <= equal_nxt;
  end

  // Exception flags pulse with out_valid only
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      underflow <= 1'b0;
      overflow <= 1'b0;
      denormal_operand <= 1'b0;
    end
    else
    begin
      underflow <= in_valid && uf_nxt;
      overflow <= in_valid && ovf_nxt;
      denormal_operand <= in_valid && denorm_op_nxt;
    end
  end

endmodule : fpscn_top

// [verification/fpscn_sink.sv]
`timescale 1ns/1ps
// ----------------------------------------
// Result sink of the pipeline
// ----------------------------------------
module fpscn_sink (
  input wire logic clk,
  input wire logic out_valid,
  output int seen
);
  // Takes every answer whole, never stalls
  always_ff @(posedge clk)
  begin
    if (out_valid)
    begin
      seen <= seen + 1;
    end
  end
endmodule : fpscn_sink

// [verification/fpscn_top_asserts.sv]
`timescale 1ns/1ps
// ----------------------------------------
// Port checker
// ----------------------------------------
module fpscn_top_asserts (
  input logic clk,
  input logic srst,
  input logic in_valid,
  input logic op_a_sign,
  input logic [fpscn_pkg::EXP_W-1:0] op_a_exp,
  input logic [fpscn_pkg::FRAC_W-1:0] op_a_frac,
  input logic res_sign,
  input logic [fpscn_pkg::SIG_W-1:0] res_sig,
  input logic out_valid,
  input fpscn_pkg::fpscn_class_t op_a_class,
  input logic op_a_negative,
  input logic [fpscn_pkg::WORD_W-1:0] result_word,
  input logic underflow,
  input logic overflow,
  input logic denormal_operand
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // Answer timing
  a_valid_follows: assert property (in_valid |=> out_valid)
    else $error("out_valid missing after transfer");
  a_valid_cause: assert property (out_valid |-> $past(in_valid))
    else $error("out_valid without transfer");
  a_word_holds: assert property (!in_valid |=> $stable(result_word) && $stable(op_a_class))
    else $error("outputs changed while idle");
  // Classification
  a_class_norm: assert property (in_valid && op_a_exp != 8'h00 && op_a_exp != 8'hff
    |=> op_a_class == fpscn_pkg::FPSCN_NORMAL)
    else $error("normal operand misclassified");
  a_class_inf: assert property (in_valid && op_a_exp == 8'hff && op_a_frac == 23'h000000
    |=> op_a_class == fpscn_pkg::FPSCN_INFINITY)
    else $error("infinity misclassified");
  a_denorm_flag: assert property (in_valid && op_a_exp == 8'h00 && op_a_frac != 23'h000000
    |=> denormal_operand)
    else $error("denormal operand not flagged");
  a_sign_kept: assert property (in_valid |=> op_a_negative == $past(op_a_sign)
    && result_word[31] == $past(res_sign))
    else $error("sign not kept");
  // Result encoding
  a_uflow_tiny: assert property (underflow |-> out_valid && result_word[30:23] == 8'h00)
    else $error("underflow without tiny result");
  a_oflow_inf: assert property (overflow |-> result_word[30:0] == 31'h7f800000)
    else $error("overflow result not infinity");
  a_zero_res: assert property (in_valid && res_sig == 24'h000000
    |=> result_word[30:0] == 31'h00000000 && !underflow)
    else $error("zero result wrong");
  c_uflow: cover property (underflow);
  c_oflow: cover property (overflow);
  c_denorm: cover property (denormal_operand ##1 out_valid);
endmodule : fpscn_top_asserts
bind fpscn_top fpscn_top_asserts fpscn_top_asserts_i (.clk(clk), .srst(srst),
  .in_valid(in_valid), .op_a_sign(op_a_sign), .op_a_exp(op_a_exp), .op_a_frac(op_a_frac),
  .res_sign(res_sign), .res_sig(res_sig), .out_valid(out_valid), .op_a_class(op_a_class),
  .op_a_negative(op_a_negative), .result_word(result_word), .underflow(underflow),
  .overflow(overflow), .denormal_operand(denormal_operand));

// [verification/testbench.sv]
`timescale 1ns/1ps
module testbench;
  logic clk, srst, iv, as, bs, rs, ov, an, aq, asn, bn, bq, bsn, eq, uf, of, dn;
  logic [7:0] ae, be;
  logic [22:0] af, bf;
  logic signed [9:0] re;
  logic [23:0] rsig;
  logic [31:0] rw, x_rw;
  logic [3:0] x_p;
  logic [2:0] x_af, x_bf;
  logic x_eq;
  fpscn_pkg::fpscn_class_t ac, bc, x_ac, x_bc;
  int err_total, samples_checked, sent, seen, i;
  logic [31:0] vec [12] = '{32'h0, 32'h80000000, 32'h1, 32'h807fffff, 32'h800000, 32'h7f7fffff,
    32'h7f800000, 32'hff800000, 32'h7fc00001, 32'h7f800001, 32'hffc00000, 32'hff800001};
  int rex [12] = '{0, -120, -126, -127, -150, -149, 128, 127, -512, 0, -129, 5};
  int rsx [12] = '{0, 1, 'h800000, 'h800000, 'hffffff, 'hffffff, 'h800000, 'hffffff, 1, 1,
    'hae0000, 'h400000};
  fpscn_top fpscn_top_i (.clk(clk), .srst(srst), .in_valid(iv), .op_a_sign(as),
    .op_a_exp(ae), .op_a_frac(af), .op_b_sign(bs), .op_b_exp(be), .op_b_frac(bf),
    .res_sign(rs), .res_exp(re), .res_sig(rsig), .out_valid(ov), .op_a_class(ac),
    .op_a_negative(an), .op_a_quiet_not_a_number(aq), .op_a_signaling_not_a_number(asn),
    .op_b_class(bc), .op_b_negative(bn), .op_b_quiet_not_a_number(bq),
    .op_b_signaling_not_a_number(bsn), .ops_equal(eq), .result_word(rw), .underflow(uf),
    .overflow(of), .denormal_operand(dn));
  fpscn_sink fpscn_sink_i (.clk(clk), .out_valid(ov), .seen(seen));
  // ----------------------------------------
  // Reference model
  // ----------------------------------------
  function automatic fpscn_pkg::fpscn_class_t f_cls(input logic [31:0] w);
    if (w[30:23] == 8'h00)
      return (w[22:0] == 0) ? fpscn_pkg::FPSCN_ZERO : fpscn_pkg::FPSCN_DENORMAL;
    if (w[30:23] != 8'hff)
      return fpscn_pkg::FPSCN_NORMAL;
    if (w[22:0] == 0)
      return fpscn_pkg::FPSCN_INFINITY;
    return (w == 32'hffc00000) ? fpscn_pkg::FPSCN_INDEFINITE : fpscn_pkg::FPSCN_NAN;
  endfunction : f_cls
  // Sign, quiet and signaling flags of one operand
  function automatic logic [2:0] f_kind(input logic [31:0] w);
    fpscn_pkg::fpscn_class_t c;
    c = f_cls(w);
    return {w[31], c inside {fpscn_pkg::FPSCN_NAN, fpscn_pkg::FPSCN_INDEFINITE} && w[22],
      c == fpscn_pkg::FPSCN_NAN && !w[22]};
  endfunction : f_kind
  // Normalize, else denormalize by gradual underflow
  function automatic logic [31:0] f_res(input logic s, input int e, input int m,
    output logic u, output logic o);
    u = 0;
    o = 0;
    if (m == 0)
      return {s, 31'h0};
    while (m < 'h800000 && e > -126)
    begin
      m = m << 1;
      e = e - 1;
    end
    o = e > 127;
    if (o)
      return {s, 31'h7f800000};
    if (e < -126)
      m = (-126 - e >= 24) ? 0 : m >> (-126 - e);
    u = m < 'h800000;
    return {s, u ? 8'h00 : 8'(e + 127), m[22:0]};
  endfunction : f_res
  // ----------------------------------------
  // Compare tasks and verdict
  // ----------------------------------------
  task chk_w(string n, logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk_w
  task chk_c(string n, fpscn_pkg::fpscn_class_t e, fpscn_pkg::fpscn_class_t g);
    chk_w(n, 32'(e), 32'(g));
  endtask : chk_c
  task end_of_test;
    if (err_total == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  // One cycle of stimulus, then compare what came back
  task step(logic v, logic [31:0] a, logic [31:0] b, logic s, int e, int m);
    logic u, o;
    iv = v;
    {as, ae, af} = a;
    {bs, be, bf} = b;
    rs = s;
    re = e[9:0];
    rsig = m[23:0];
    x_p = 4'h0;
    if (v)
    begin
      sent++;
      x_ac = f_cls(a);
      x_bc = f_cls(b);
      x_af = f_kind(a);
      x_bf = f_kind(b);
      x_eq = !(x_af[1] || x_af[0] || x_bf[1] || x_bf[0]) && (a == b ||
        (x_ac == fpscn_pkg::FPSCN_ZERO && x_bc == fpscn_pkg::FPSCN_ZERO));
      x_rw = f_res(s, e, m, u, o);
      x_p = {1'b1, u, o, x_ac == fpscn_pkg::FPSCN_DENORMAL || x_bc == fpscn_pkg::FPSCN_DENORMAL};
    end
    @(negedge clk);
    chk_c("a_class", x_ac, ac);
    chk_c("b_class", x_bc, bc);
    chk_w("a_kind", 32'(x_af), 32'({an, aq, asn}));
    chk_w("b_kind", 32'(x_bf), 32'({bn, bq, bsn}));
    chk_w("equal", 32'(x_eq), 32'(eq));
    chk_w("result", x_rw, rw);
    chk_w("pulses", 32'(x_p), 32'({ov, uf, of, dn}));
  endtask : step
  task rst(int n);
    srst = 1;
    iv = 0;
    repeat (n) @(negedge clk);
    srst = 0;
    x_ac = fpscn_pkg::FPSCN_ZERO;
    x_bc = fpscn_pkg::FPSCN_ZERO;
    {x_af, x_bf, x_eq, x_rw} = '0;
  endtask : rst
  // ----------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------
  initial
  begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    #50us;
    err_total++;
    end_of_test;
  end
  initial
  begin
    {as, ae, af, bs, be, bf, rs, re, rsig} = '0;
    {err_total, samples_checked, sent} = '0;
    void'($urandom(32'h80aa));
    rst(16);
    for (i = 0; i < 12; i++)
      step(1, vec[i], vec[(i + 1) % 12], i[0], rex[i], rsx[i]);
    step(0, vec[2], vec[3], 0, 0, 0);
    rst(2);
    step(0, vec[4], vec[5], 1, 3, 5);
    for (i = 0; i < 600; i++)
      step(1'($urandom % 2), $urandom, (i % 3 == 0) ? vec[i % 12] : $urandom,
        1'($urandom % 2), int'($urandom % 1024) - 512,
        24'(($urandom & 'hffffff) >> ($urandom % 25)));
    step(0, 0, 0, 0, 0, 0);
    chk_w("sink_count", sent, seen);
    end_of_test;
  end
endmodule : testbench
